// [verilog/clk_cfg_map.svh]
// register map and protocol constants for the output configuration port
`ifndef CLK_CFG_MAP_SVH
`define CLK_CFG_MAP_SVH
`define ADDR_WRITE        8'hd2
`define ADDR_READ         8'hd3
`define REG_OUT_EN_A      8'h00
`define REG_OUT_EN_B      8'h01
`define REG_OUT_EN_C      8'h02
`define REG_SWING         8'h03
`define REG_RSVD4         8'h04
`define REG_COUNT         8'h08
`define RST_OUT_EN_A      8'hff
`define RST_OUT_EN_B      8'h9e
`define RST_OUT_EN_C      8'h3f
`define RST_SWING         8'h55
`define RST_RSVD4         8'h03
`define RST_COUNT         8'h01
`define MASK_OUT_EN_B     8'h9e
`define MASK_OUT_EN_C     8'h3f
`define BIT_LAST          3'h7
`endif

// [verilog/clk_cfg_pkg.sv]
// types shared by the output configuration port
package clk_cfg_pkg;
  typedef struct packed {
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] en_c;
    logic [7:0] swing;
  } cfg_s;
endpackage

// [verilog/smbus_clock_output_config.sv]
// smbus target port holding the clock output enable and swing registers
//
// Summary of operation
// RQ1: acknowledge write address before index byte
// RQ2: host sends index then count, both acked
// RQ3: store data bytes at consecutive indices
// RQ4: ack every data byte; host stops after
// RQ5: host writes index, repeated start, read address
// RQ6: read returns count byte, then consecutive registers
// RQ7: read length comes from count register; the device loads it but sends bytes until the host nacks
// RQ8: host acks every byte it receives except the last
// RQ9: host nacks last byte; device releases data
// RQ10: register 0 enables, all reset one
// RQ11: register 1 enables, reserved bits six five zero
// RQ12: register 2 enables bus and fixed clocks
// RQ13: disabled outputs held low, both legs
// RQ14: register 3 holds four swing fields
// RQ15: swing codes 700 to 1000 mV, reset 01
// RQ16: register 4 reserved, resets 0x03
// RQ17: register 8 is read-write byte count
// RQ18: ignore foreign target addresses entirely
// RQ19: registers load defaults at reset
// RQ20: reserved bits ignored, read back defaults
`timescale 1ns/1ps
`include "clk_cfg_map.svh"
module smbus_clock_output_config
  import clk_cfg_pkg::*;
(
  // system
  input  wire logic       clk,
  input  wire logic       rst,
  // smbus pins
  input  wire logic       smb_clk,
  input  wire logic       smb_data_in,
  output logic            smb_data_out,
  output logic            smb_data_oe_n,
  // running clocks from the synthesizer core
  input  wire logic [18:0] clk_run,
  input  wire logic [10:0] clk_run_n,
  // gated outputs: [18:8] differential true legs, then single ended
  output logic [18:0]     clk_gated,
  output logic [10:0]     clk_gated_n,
  // swing fields for the output drivers
  output logic [1:0]      proc_swing_field,
  output logic [1:0]      ref_swing_field,
  output logic [1:0]      video_swing_field,
  output logic [1:0]      storage_swing_field
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge/condition detection
  // ----------------------------------------------------------------
  logic [1:0] scl_sync, sda_sync;
  logic       scl_d, sda_d;
  logic       scl_rise, scl_fall, start_det, stop_det;

  // two stages per pin, then one history stage for edge detection
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], smb_clk};
      sda_sync <= {sda_sync[0], smb_data_in};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  assign scl_rise  = scl_sync[1] & ~scl_d;
  assign scl_fall  = ~scl_sync[1] & scl_d;
  assign start_det = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign stop_det  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK,
    ST_TX, ST_TX_ACK, ST_HOLD
  } state_e;

  typedef enum logic [1:0] { PH_INDEX, PH_COUNT, PH_DATA } phase_e;

  state_e     state, next_state;
  phase_e     phase, next_phase;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] index, next_index;
  logic [7:0] remain, next_remain;
  logic       first_tx, next_first_tx;
  logic       drive_low, next_drive_low;
  logic       sda_bit, next_sda_bit;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] reg_en_a, reg_en_b, reg_en_c, reg_swing, reg_rsvd4, reg_count;

  // register read decode; reserved bits return their defaults
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    unique case (a)
      `REG_OUT_EN_A: reg_read = reg_en_a;
      `REG_OUT_EN_B: reg_read = reg_en_b;                 // RQ20
      `REG_OUT_EN_C: reg_read = reg_en_c;                 // RQ20
      `REG_SWING:    reg_read = reg_swing;
      `REG_RSVD4:    reg_read = reg_rsvd4;                // RQ16
      `REG_COUNT:    reg_read = reg_count;                // RQ17
      default:       reg_read = 8'h00;
    endcase
  endfunction

  // next-state logic, decisions made on synchronised scl edges and start/stop conditions
  always_comb
  begin
    next_state     = state;
    next_phase     = phase;
    next_bit_cnt   = bit_cnt;
    next_shreg     = shreg;
    next_index     = index;
    next_remain    = remain;
    next_first_tx  = first_tx;
    next_drive_low = drive_low;
    next_sda_bit   = sda_bit;
    wr_en          = 1'b0;
    wr_addr        = index;
    if (stop_det)
    begin
      next_state     = ST_IDLE;
      next_drive_low = 1'b0;                              // RQ9
    end
    else if (start_det)
    begin
      // repeated start keeps the index written before it
      next_state     = ST_ADDR;                           // RQ5
      next_bit_cnt   = 3'h0;
      next_drive_low = 1'b0;
      next_first_tx  = 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE, ST_HOLD: ;                               // RQ18
        ST_ADDR, ST_RX:
          if (scl_rise)
          begin
            next_shreg   = {shreg[6:0], sda_sync[1]};
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == `BIT_LAST)
              next_state = (state == ST_ADDR) ? ST_ADDR_ACK : ST_RX_ACK;
          end
        ST_ADDR_ACK:
          if (scl_fall && !drive_low)
          begin
            if (shreg == `ADDR_WRITE)
            begin
              next_drive_low = 1'b1;                      // RQ1
              next_phase     = PH_INDEX;
            end
            else if (shreg == `ADDR_READ)
            begin
              next_drive_low = 1'b1;                      // RQ5
              next_first_tx  = 1'b1;
              next_remain    = reg_count;                 // RQ7
              next_shreg     = reg_count;                 // RQ6
            end
            else
              next_state = ST_HOLD;                       // RQ18
          end
          else if (scl_fall)
          begin
            next_drive_low = 1'b0;
            next_bit_cnt   = 3'h0;
            // shreg already holds the count byte, so use the read flag
            if (first_tx)
            begin
              next_state     = ST_TX;
              next_sda_bit   = shreg[7];
              next_drive_low = ~shreg[7];
            end
            else
              next_state = ST_RX;
          end
        ST_RX_ACK:
          if (scl_fall && !drive_low)
          begin
            next_drive_low = 1'b1;                        // RQ2 RQ4
            unique case (phase)
              PH_INDEX:
              begin
                next_index = shreg;
                next_phase = PH_COUNT;
              end
              PH_COUNT:
              begin
                next_remain = shreg;
                next_phase  = PH_DATA;
              end
              PH_DATA:
              begin
                wr_en      = (remain != 8'h00);           // RQ3
                next_index = index + 8'h01;
                if (remain != 8'h00)
                  next_remain = remain - 8'h01;
              end
            endcase
          end
          else if (scl_fall)
          begin
            next_drive_low = 1'b0;
            next_bit_cnt   = 3'h0;
            next_state     = ST_RX;
          end
        ST_TX:
          if (scl_fall)
          begin
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == `BIT_LAST)
            begin
              next_state     = ST_TX_ACK;
              next_drive_low = 1'b0;                      // release for ack
            end
            else
            begin
              next_shreg     = {shreg[6:0], 1'b0};
              next_drive_low = ~shreg[6];
            end
          end
        ST_TX_ACK:
          if (scl_rise)
          begin
            if (sda_sync[1])
              next_state = ST_HOLD;                       // RQ9
            else
            begin
              // after the count byte, stream from the written index
              next_shreg = reg_read(index);               // RQ6
              if (!first_tx)
                next_index = index + 8'h01;
              if (!first_tx)
                next_shreg = reg_read(index + 8'h01);
              next_first_tx = 1'b0;
              next_bit_cnt  = 3'h0;
            end
          end
          else if (scl_fall)
          begin
            // leave the ack clock only on its falling edge, else bit 7
            // would be shifted out before it was ever driven
            next_state     = ST_TX;
            next_drive_low = ~shreg[7];                   // RQ8
          end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // protocol registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state     <= ST_IDLE;
      phase     <= PH_INDEX;
      bit_cnt   <= 3'h0;
      shreg     <= 8'h00;
      index     <= 8'h00;
      remain    <= 8'h00;
      first_tx  <= 1'b0;
      drive_low <= 1'b0;
      sda_bit   <= 1'b1;
    end
    else
    begin
      state     <= next_state;
      phase     <= next_phase;
      bit_cnt   <= next_bit_cnt;
      shreg     <= next_shreg;
      index     <= next_index;
      remain    <= next_remain;
      first_tx  <= next_first_tx;
      drive_low <= next_drive_low;
      sda_bit   <= next_sda_bit;
    end
  end

  // open drain: only ever pull low, enable active low while driving
  assign smb_data_out  = 1'b0;
  assign smb_data_oe_n = ~drive_low;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  cfg_s cfg, next_cfg;
  logic [7:0] next_count;

  // reserved bits are masked so writes cannot disturb them
  always_comb
  begin
    next_cfg   = cfg;
    next_count = reg_count;
    if (wr_en)
    begin
      unique case (wr_addr)
        `REG_OUT_EN_A: next_cfg.en_a = shreg;             // RQ10
        `REG_OUT_EN_B: next_cfg.en_b = shreg & `MASK_OUT_EN_B; // RQ11 RQ20
        `REG_OUT_EN_C: next_cfg.en_c = shreg & `MASK_OUT_EN_C; // RQ12 RQ20
        `REG_SWING:    next_cfg.swing = shreg;            // RQ14
        `REG_COUNT:    next_count = shreg;                // RQ17
        default: ;                                        // RQ16 RQ20
      endcase
    end
  end

  // defaults loaded under reset before any transaction is seen
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg.en_a  <= `RST_OUT_EN_A;                         // RQ19
      cfg.en_b  <= `RST_OUT_EN_B;
      cfg.en_c  <= `RST_OUT_EN_C;
      cfg.swing <= `RST_SWING;                            // RQ15
      reg_count <= `RST_COUNT;
    end
    else
    begin
      cfg       <= next_cfg;
      reg_count <= next_count;
    end
  end

  assign reg_en_a  = cfg.en_a;
  assign reg_en_b  = cfg.en_b;
  assign reg_en_c  = cfg.en_c;
  assign reg_swing = cfg.swing;
  assign reg_rsvd4 = `RST_RSVD4;                          // RQ16

  // ----------------------------------------------------------------
  // output gating
  // ----------------------------------------------------------------
  logic [18:0] en_vec;
  logic [18:0] next_gated;
  logic [10:0] next_gated_n;

  // order: en_a[7:0], proc [4:1], legacy, bus [5:1], fixed
  assign en_vec = {cfg.en_a, cfg.en_b[4:1], cfg.en_b[7],
                   cfg.en_c[5:1], cfg.en_c[0]};

  always_comb
  begin
    next_gated   = clk_run & en_vec;                      // RQ13
    next_gated_n = clk_run_n & en_vec[18:8];              // RQ13
  end

  // registered so gated clock outputs come straight from flip-flops
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clk_gated   <= 19'h00000;
      clk_gated_n <= 11'h000;
    end
    else
    begin
      clk_gated   <= next_gated;
      clk_gated_n <= next_gated_n;
    end
  end

  assign proc_swing_field    = cfg.swing[7:6];            // RQ14
  assign ref_swing_field     = cfg.swing[5:4];
  assign video_swing_field   = cfg.swing[3:2];
  assign storage_swing_field = cfg.swing[1:0];

endmodule // smbus_clock_output_config

// [sim/smbus_cfg_checker.sv]
// pin-level assertions for the smbus clock output configuration port
`timescale 1ns/1ps
module smbus_cfg_checker
(
  // system
  input wire logic        clk,
  input wire logic        rst,
  // smbus pins
  input wire logic        smb_clk,
  input wire logic        smb_data_in,
  input wire logic        smb_data_out,
  input wire logic        smb_data_oe_n,
  // clocks and swing
  input wire logic [18:0] clk_run,
  input wire logic [10:0] clk_run_n,
  input wire logic [18:0] clk_gated,
  input wire logic [10:0] clk_gated_n,
  input wire logic [1:0]  proc_swing_field,
  input wire logic [1:0]  ref_swing_field,
  input wire logic [1:0]  video_swing_field,
  input wire logic [1:0]  storage_swing_field
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a pulled bit must outlast the scl high phase that samples it
  sequence held_low;
    !smb_data_oe_n [*6];
  endsequence
  out_zero_a: assert property (smb_data_out == 1'b0)
    else $error("data output not tied low");
  rst_idle_a: assert property ($fell(rst) |-> smb_data_oe_n &&
    clk_gated == '0 && clk_gated_n == '0) else $error("reset state wrong");
  rst_swing_a: assert property ($fell(rst) |-> {proc_swing_field,
    ref_swing_field, video_swing_field, storage_swing_field} == 8'h55)
    else $error("swing reset wrong");
  gate_default_a: assert property ($fell(rst) |=>
    clk_gated == $past(clk_run) && clk_gated_n == $past(clk_run_n))
    else $error("outputs not enabled after reset");
  gate_low_a: assert property ((clk_gated & ~$past(clk_run)) == '0)
    else $error("gated output high without its clock");
  gate_leg_a: assert property ((clk_gated_n & ~$past(clk_run_n)) == '0)
    else $error("complement leg high without its clock");
  sda_low_phase_a: assert property ($changed(smb_data_oe_n) &&
    !$past(rst) |-> !smb_clk && $past(!smb_clk, 2))
    else $error("data moved outside scl low");
  drive_hold_a: assert property ($fell(smb_data_oe_n) |-> held_low)
    else $error("data released too early");
endmodule // smbus_cfg_checker

bind smbus_clock_output_config smbus_cfg_checker smbus_cfg_checker_i (
  .clk, .rst, .smb_clk, .smb_data_in, .smb_data_out, .smb_data_oe_n,
  .clk_run, .clk_run_n, .clk_gated, .clk_gated_n, .proc_swing_field,
  .ref_swing_field, .video_swing_field, .storage_swing_field);

// [sim/smb_host.sv]
// smbus host model driving scl and pulling the shared data line
`timescale 1ns/1ps
module smb_host
(
  // system
  input  wire logic clk,
  // bus
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe_n
);
  // ----------
  // bus timing
  // ----------
  // idle bus: scl stands high, data released to the pull-up
  initial
  begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  task automatic half(input int n = 5);
    repeat (n) @(negedge clk);
  endtask
  // data moves mid low phase so it never races an scl edge
  task automatic bit_x(input logic b, output logic r);
    half(2);
    sda_oe_n = b;
    half(3);
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    half(2);
    sda_oe_n = 1'b1;
    half(3);
    scl = 1'b1;
    half();
    sda_oe_n = 1'b0;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    half(2);
    sda_oe_n = 1'b0;
    half(3);
    scl = 1'b1;
    half();
    sda_oe_n = 1'b1;
    half();
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  // ack every byte, nack only the last one
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(last, r);
  endtask
endmodule // smb_host

// [sim/test_smbus_clock_output_config.sv]
// self-checking bench for the smbus clock output configuration port
`timescale 1ns/1ps
`include "clk_cfg_map.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_smbus_clock_output_config;
  logic        clk, rst, scl, host_oe_n, sda, dev_out, dev_oe_n;
  logic [18:0] run, gated;
  logic [10:0] run_n, gated_n;
  logic [1:0]  sw_p, sw_r, sw_v, sw_s;
  logic [7:0]  res, exp_v, wdat [0:4], mdl [0:15], exp_q [$];
  logic [31:0] seed;
  int          error_cnt, checked, cycles;
  event        res_ev;
  // open drain with pull-up: high unless someone pulls
  assign sda = host_oe_n & dev_oe_n;
  smbus_clock_output_config smbus_clock_output_config_i (.clk, .rst,
    .smb_clk(scl), .smb_data_in(sda), .smb_data_out(dev_out),
    .smb_data_oe_n(dev_oe_n), .clk_run(run), .clk_run_n(run_n),
    .clk_gated(gated), .clk_gated_n(gated_n), .proc_swing_field(sw_p),
    .ref_swing_field(sw_r), .video_swing_field(sw_v),
    .storage_swing_field(sw_s));
  smb_host smb_host_i (.clk, .sda, .scl, .sda_oe_n(host_oe_n));
  // ----------
  // helpers
  // ----------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // random running clocks so every gate sees both levels
  always @(negedge clk) {run_n, run} <= 30'(xs());
  // pop once: the compare macro reads its expected value twice
  always @(res_ev)
  begin
    exp_v = exp_q.pop_front();
    `CHK(res, exp_v)
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic put(input logic [7:0] b, input logic ack);
    logic a;
    exp_q.push_back({7'h0, ack});
    smb_host_i.wr_byte(b, a);
    res = {7'h0, a};
    ->res_ev;
  endtask
  task automatic get(input logic [7:0] e, input logic last);
    logic [7:0] b;
    exp_q.push_back(e);
    smb_host_i.rd_byte(last, b);
    res = b;
    ->res_ev;
  endtask
  task automatic blk_wr(input logic [7:0] idx, input int n);
    smb_host_i.start();
    put(`ADDR_WRITE, 1'b1);
    put(idx, 1'b1);
    put(8'(n), 1'b1);
    for (int i = 0; i < n; i++) put(wdat[i], 1'b1);
    smb_host_i.stop();
  endtask
  task automatic blk_rd(input logic [7:0] idx, input int n);
    smb_host_i.start();
    put(`ADDR_WRITE, 1'b1);
    put(idx, 1'b1);
    smb_host_i.start();
    put(`ADDR_READ, 1'b1);
    get(mdl[8], 1'b0);
    for (int i = 0; i < n; i++) get(mdl[idx + i], i == n - 1);
    smb_host_i.stop();
  endtask
  task automatic chk_out();
    logic [18:0] en;
    en = {mdl[0], mdl[1][4:1], mdl[1][7], mdl[2][5:1], mdl[2][0]};
    @(negedge clk);
    `CHK(gated, run & en)
    `CHK(gated_n, run_n & en[18:8])
    `CHK({sw_p, sw_r, sw_v, sw_s}, mdl[3])
  endtask
  // main sequence: defaults, foreign address, writes, count register
  initial
  begin
    seed = 32'h8b13b6b6;
    rst = 1'b1;
    {run_n, run} = '0;
    res = '0;
    mdl = '{0: 8'hff, 1: 8'h9e, 2: 8'h3f, 3: 8'h55, 4: 8'h03, 8: 8'h01,
      default: 8'h00};
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk_out();
    blk_rd(8'h00, 5);
    $display("test defaults done");
    smb_host_i.start();
    put(8'ha4, 1'b0);
    smb_host_i.stop();
    $display("test foreign address done");
    for (int k = 0; k < 2; k++)
    begin
      for (int i = 0; i < 5; i++) wdat[i] = k ? 8'(xs()) : 8'h00;
      if (k) wdat[3] = 8'h1b; // all four swing codes at once
      blk_wr(8'h00, 5);
      mdl[0] = wdat[0];
      mdl[1] = wdat[1] & 8'h9e;
      mdl[2] = wdat[2] & 8'h3f;
      mdl[3] = wdat[3];
      chk_out();
      blk_rd(8'h00, 5);
      $display("test write pass %0d done", k);
    end
    wdat[0] = 8'h03;
    blk_wr(8'h08, 1);
    mdl[8] = 8'h03;
    wdat[0] = 8'hff;
    wdat[1] = 8'he4;
    blk_wr(8'h02, 2);
    mdl[2] = 8'h3f;
    mdl[3] = 8'he4;
    chk_out();
    blk_rd(8'h01, 3);
    $display("test count register done");
    test_done();
  end
endmodule // test_smbus_clock_output_config
